/* design/tfmc_pkg.sv */
// Package with register map, field layout and shared types for the filter mode control block
package tfmc_pkg;

  // ***************************************************************
  // Register map and field positions
  // ***************************************************************
  localparam logic [3:0] TFMC_ADDR_FILTER_MODE = 4'h5;
  localparam logic [3:0] TFMC_ADDR_STATUS      = 4'h9;
  localparam logic [7:0] TFMC_FILTER_MODE_RST  = 8'h00;
  localparam int         TFMC_DEC_LSB          = 0;
  localparam int         TFMC_REAL_BIT         = 4;
  localparam int         TFMC_OFFSET_BIT       = 5;
  localparam int         TFMC_FLIP_BIT         = 6;
  localparam int         TFMC_RAMP_BIT         = 7;

  // ***************************************************************
  // Sample widths and ramp limits
  // ***************************************************************
  localparam int          TFMC_SAMPLE_W  = 12;
  localparam logic [11:0] TFMC_RAMP_MIN  = 12'h800;
  localparam logic [11:0] TFMC_RAMP_MAX  = 12'h7FF;
  localparam logic [6:0]  TFMC_DIV_MAX   = 7'h40;

  // Decoded mode of the filter mode register
  typedef struct packed {
    logic       ramp_sel;
    logic       flip;
    logic       offset;
    logic       real_out;
    logic [2:0] rate_divide_select;
  } tfmc_mode_t;

  // Register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tfmc_bus_req_t;

  // Output-side spectral controls handed to the datapath
  typedef struct packed {
    logic [6:0] divide;      // Output rate is input rate over this
    logic       real_out;
    logic       offset_en;
    logic       invert_zero;
    logic       invert_quarter;
  } tfmc_ctrl_t;

endpackage

/* design/tfmc_rate_div.sv */
// Output sample-rate divider producing a one-cycle output strobe
`timescale 1ns/1ps
`default_nettype none
module tfmc_rate_div
  import tfmc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // Control
  input  wire logic [6:0] divide_i,
  // Strobe
  output logic            out_stb_o
);

  typedef struct packed {
    logic [6:0] cnt;
  } tfmc_div_state_t;

  tfmc_div_state_t state_q;
  tfmc_div_state_t state_d;

  // Count up to divide-1 and wrap; a count left past a smaller divide wraps at once
  always_comb begin
    state_d = state_q;
    if (state_q.cnt >= divide_i - 7'h01) begin
      state_d.cnt = 7'h00;
    end else begin
      state_d.cnt = state_q.cnt + 7'h01;
    end
  end

  assign out_stb_o = (state_q.cnt == 7'h00);

  // State register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

endmodule
`default_nettype wire

/* design/tfmc_top.sv */
// Filter mode control: mode register, rate select, spectral controls and test ramp
// Notes on behaviour
// - Bits 0-2 select output rate divide
// - Complex: 0,1 full; 2-7 /2../64. Real: 2-7 /1../32
// - Bit 4 selects real output samples
// - Bit 5 offsets complex spectrum to Fo/2
// - Complex mode: bit 6 high inverts about zero
// - Real mode: bit 6 low inverts about Fo/4
// - Bit 7 feeds internal ramp, -2048 to 2047
// - Control bits active high, except real flip
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module tfmc_top
  import tfmc_pkg::*;
#(
  parameter int SAMPLE_W = TFMC_SAMPLE_W
)(
  // Clock and reset
  input  wire logic                sys_clk_i,
  input  wire logic                rst_b_i,
  // Register port
  input  wire logic [3:0]          reg_addr_i,
  input  wire logic [7:0]          reg_wdata_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  output logic      [7:0]          reg_rdata_o,
  // Sample input
  input  wire logic [SAMPLE_W-1:0] sample_i,
  // Datapath feed and controls
  output logic      [SAMPLE_W-1:0] dp_sample_o,
  output logic                     out_stb_o,
  output tfmc_ctrl_t               ctrl_o
);

  // ***************************************************************
  // Elaboration checks
  // ***************************************************************
  // The ramp limits are 12-bit codes, so the sample path must match them
  if (SAMPLE_W != TFMC_SAMPLE_W) begin : g_bad_width
    $error("Ramp range needs a 12-bit sample path");
  end
  // The wrap from top to bottom code must be the counter's own carry
  if (TFMC_RAMP_MAX + 12'h001 != TFMC_RAMP_MIN) begin : g_bad_ramp
    $error("Ramp limits are not one step apart");
  end
  // Readback places the seven stored bits around the unused bit 3
  if ($bits(tfmc_mode_t) != 7) begin : g_bad_mode
    $error("Mode record must hold seven bits");
  end

  // ***************************************************************
  // Reset release
  // ***************************************************************
  logic [1:0] rst_sync_q;
  logic       rst_b;

  // Asynchronous assert, two-flop release
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_b = rst_sync_q[1];

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    tfmc_mode_t          mode;
    logic [7:0]          rdata;
    logic [SAMPLE_W-1:0] ramp;
    logic [SAMPLE_W-1:0] dp_sample;
    tfmc_ctrl_t          ctrl;
  } tfmc_state_t;

  // Registered state and its next value
  tfmc_state_t   state_q;
  tfmc_state_t   state_d;
  // Bus request bundle and the divider's strobe
  tfmc_bus_req_t req;
  logic          div_stb;

  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  // ***************************************************************
  // Register decode
  // ***************************************************************
  logic       mode_wr_hit;
  tfmc_mode_t mode_wr;
  logic [7:0] mode_rdback;

  // Writes to any other address fall through untouched
  assign mode_wr_hit = req.wr && (req.addr == TFMC_ADDR_FILTER_MODE);

  // Field split of a host write; bit 3 has no storage behind it
  assign mode_wr = '{
    ramp_sel:           req.wdata[TFMC_RAMP_BIT],
    flip:               req.wdata[TFMC_FLIP_BIT],
    offset:             req.wdata[TFMC_OFFSET_BIT],
    real_out:           req.wdata[TFMC_REAL_BIT],
    rate_divide_select: req.wdata[TFMC_DEC_LSB +: 3]
  };

  // Readback image of the stored mode; the unused bit reads zero
  assign mode_rdback = {state_q.mode.ramp_sel, state_q.mode.flip, state_q.mode.offset,
                        state_q.mode.real_out, 1'b0, state_q.mode.rate_divide_select};

  // ***************************************************************
  // Test ramp and input select
  // ***************************************************************
  logic [SAMPLE_W-1:0] ramp_next;
  logic [SAMPLE_W-1:0] src_sample;

  // The ramp runs even while unselected, so turning it on lands mid-sweep
  assign ramp_next  = (state_q.ramp == TFMC_RAMP_MAX) ? TFMC_RAMP_MIN : state_q.ramp + 12'h001;
  assign src_sample = state_q.mode.ramp_sel ? state_q.ramp : sample_i;

  // Divide for a given select and output type; always a power of two,
  // so the strobe count over 64 cycles is exact
  function automatic logic [6:0] rate_divide(input logic [2:0] sel, input logic real_out);
    logic [6:0] d;
    d = 7'h01;
    // Real codes 0 and 1 have no listed rate and fall back to the input rate
    if (real_out) begin
      if (sel >= 3'h2) begin
        d = 7'h01 << (sel - 3'h2);
      end
    end else if (sel >= 3'h2) begin
      d = 7'h01 << (sel - 3'h1);
    end
    return d;
  endfunction

  // Spectral controls for one mode; the flip bit reads inverted in real mode,
  // and the offset bit only has meaning for complex output
  function automatic tfmc_ctrl_t spectral_ctrl(input tfmc_mode_t m);
    tfmc_ctrl_t c;
    c                = '0;
    c.divide         = rate_divide(m.rate_divide_select, m.real_out);
    c.real_out       = m.real_out;
    c.offset_en      = !m.real_out && m.offset;
    c.invert_zero    = !m.real_out && m.flip;
    c.invert_quarter = m.real_out && !m.flip;
    return c;
  endfunction

  // ***************************************************************
  // Next-state logic
  // ***************************************************************
  always_comb begin
    state_d       = state_q;
    state_d.rdata = 8'h00;

    // Register write; the whole mode changes at once so no half-set mode is seen
    if (mode_wr_hit) begin
      state_d.mode = mode_wr;
    end

    // Read data for the cycle after the strobe; unmapped reads give zero
    if (req.rd) begin
      case (req.addr)
        TFMC_ADDR_FILTER_MODE: begin
          state_d.rdata = mode_rdback;
        end
        TFMC_ADDR_STATUS: begin
          state_d.rdata = {1'b0, state_q.ctrl.divide};
        end
        default: begin
          state_d.rdata = 8'h00;
        end
      endcase
    end

    // Ramp step and input select; registered so the datapath sees a clean sample
    // The select follows the stored mode, so it lands two cycles after the write
    state_d.ramp      = ramp_next;
    state_d.dp_sample = src_sample;

    // Spectral controls decoded from the stored mode; held until the next write
    state_d.ctrl = spectral_ctrl(state_q.mode);
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  always_ff @(posedge sys_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      state_q             <= '0;
      state_q.mode        <= {TFMC_FILTER_MODE_RST[7:4], TFMC_FILTER_MODE_RST[2:0]};
      state_q.ramp        <= TFMC_RAMP_MIN;
      state_q.ctrl.divide <= 7'h01;
    end else begin
      state_q <= state_d;
    end
  end

  // ***************************************************************
  // Output rate strobe
  // ***************************************************************
  tfmc_rate_div u_rate_div (
    .clk_i     (sys_clk_i),
    .rst_b_i   (rst_b),
    .divide_i  (state_q.ctrl.divide),
    .out_stb_o (div_stb)
  );

  // ***************************************************************
  // Outputs
  // ***************************************************************
  // Data outputs come straight from state flops; the strobe from the divider count
  assign out_stb_o   = div_stb;
  assign reg_rdata_o = state_q.rdata;
  assign dp_sample_o = state_q.dp_sample;
  assign ctrl_o      = state_q.ctrl;

endmodule
`default_nettype wire

/* test/tfmc_host.sv */
// Host model driving the register port
`timescale 1ns/1ps
`default_nettype none
module tfmc_host (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output var  logic [3:0] addr_o = 4'h0,
  output var  logic [7:0] wdata_o = 8'h00,
  output var  logic       wr_o = 1'b0,
  output var  logic       rd_o = 1'b0
);
  // One-cycle write; data inverted once released so stale data never looks valid
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask
  // Write then read with no gap between the two strobes
  task automatic wr_rd(input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1;
    q = rdata_i;
  endtask
  // One-cycle read; data taken in the following cycle only
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1;
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

/* test/tfmc_top_chk.sv */
// Port checker for the filter mode control block
`timescale 1ns/1ps
`default_nettype none
module tfmc_top_chk
  import tfmc_pkg::*;
(
  input wire logic       sys_clk_i,
  input wire logic       rst_b_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [11:0] sample_i,
  input wire logic [11:0] dp_sample_o,
  input wire logic       out_stb_o,
  input wire tfmc_ctrl_t ctrl_o
);
  // ********
  // Mode write sequences
  // ********
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_wr;
    reg_wr_i && reg_addr_i == TFMC_ADDR_FILTER_MODE;
  endsequence
  // Three quiet cycles cover the two-cycle select latency with margin
  sequence s_quiet;
    (!reg_wr_i) [*3];
  endsequence
  a_mode_readback: assert property (s_wr ##1 (reg_rd_i && reg_addr_i == TFMC_ADDR_FILTER_MODE)
    |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'hF7)) else $error("readback");
  a_real_sel: assert property (s_wr |-> ##2 ctrl_o.real_out == $past(reg_wdata_i[4], 2)) else $error("real");
  a_offset_cplx: assert property (s_wr |-> ##2 ctrl_o.offset_en ==
    ($past(reg_wdata_i[5], 2) && !$past(reg_wdata_i[4], 2))) else $error("offset");
  a_flip_zero: assert property (s_wr |-> ##2 ctrl_o.invert_zero ==
    ($past(reg_wdata_i[6], 2) && !$past(reg_wdata_i[4], 2))) else $error("flip zero");
  a_flip_quarter: assert property (s_wr |-> ##2 ctrl_o.invert_quarter ==
    (!$past(reg_wdata_i[6], 2) && $past(reg_wdata_i[4], 2))) else $error("flip quarter");
  a_full_rate: assert property (ctrl_o.divide == 7'h01 && $past(ctrl_o.divide) == 7'h01 |-> out_stb_o)
    else $error("strobe");
  a_ramp_step: assert property ((s_wr and reg_wdata_i[7]) ##1 s_quiet
    |=> dp_sample_o == $past(dp_sample_o) + 12'h001) else $error("ramp");
  a_sample_pass: assert property ((s_wr and !reg_wdata_i[7]) ##1 s_quiet
    |=> dp_sample_o == $past(sample_i)) else $error("pass");
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00) else $error("rdata idle");
endmodule
bind tfmc_top tfmc_top_chk u_chk (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .sample_i(sample_i), .dp_sample_o(dp_sample_o), .out_stb_o(out_stb_o), .ctrl_o(ctrl_o));
`default_nettype wire

/* test/tuner_filter_mode_control_bench.sv */
// Testbench for the filter mode control block
`timescale 1ns/1ps
`default_nettype none
module tuner_filter_mode_control_bench;
  import tfmc_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, rv;
  logic wr, rd, stb;
  logic [11:0] smp = 12'h000, dp;
  tfmc_ctrl_t ctrl;
  int bad_count = 0, tests_run = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  // Input moves every cycle so a stale pass-through shows
  always @(posedge sys_clk_i) smp <= smp + 12'h135;
  tfmc_host host (.clk_i(sys_clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  tfmc_top dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .sample_i(smp), .dp_sample_o(dp),
    .out_stb_o(stb), .ctrl_o(ctrl));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Foreign write ignored, foreign read empty, status shows divide
  task automatic t_unmapped();
    host.wr(4'h3, 8'hFF);
    host.rd(4'h3, rv);
    chk(rv, 8'h00);
    host.rd(TFMC_ADDR_FILTER_MODE, rv);
    chk(rv, 8'h00);
    host.rd(TFMC_ADDR_STATUS, rv);
    chk(rv, 8'h01);
  endtask
  // All codes in both modes, offset and flip; bit 3 set to prove it reads 0
  task automatic t_modes();
    logic [7:0] m;
    logic [6:0] dv;
    int n;
    for (int i = 0; i < 64; i++) begin
      m = {1'b0, i[4], i[5], i[3], 1'b1, i[2:0]};
      dv = m[4] ? (m[2:0] < 3 ? 7'h01 : 7'h01 << (m[2:0] - 3'd2)) : (m[2:0] < 2 ? 7'h01 : 7'h01 << (m[2:0] - 3'd1));
      host.wr_rd(TFMC_ADDR_FILTER_MODE, m, rv);
      chk(rv, m & 8'hF7);
      chk(ctrl, {dv, m[4], m[5] & ~m[4], m[6] & ~m[4], ~m[6] & m[4]});
      n = 0;
      repeat (64) begin
        @(posedge sys_clk_i);
        #1;
        n += stb;
      end
      chk(n[15:0], 16'(64 / dv));
    end
  endtask
  // Ramp steps by one each clock and wraps once per 4096; then input passes again
  task automatic t_ramp();
    logic [11:0] prev;
    int wraps;
    host.wr(TFMC_ADDR_FILTER_MODE, 8'h80);
    repeat (3) @(posedge sys_clk_i);
    #1;
    prev = dp;
    wraps = 0;
    repeat (4096) begin
      @(posedge sys_clk_i);
      #1;
      chk(dp, 12'(prev + 12'h001));
      wraps += (prev == TFMC_RAMP_MAX);
      prev = dp;
    end
    chk(wraps[15:0], 16'h0001);
    host.wr(TFMC_ADDR_FILTER_MODE, 8'h00);
    repeat (3) @(posedge sys_clk_i);
    repeat (8) begin
      @(posedge sys_clk_i);
      #1;
      chk(dp, 12'(smp - 12'h135));
    end
  endtask
  // Reset, then every scenario in turn
  initial begin
    repeat (16) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk(ctrl, {7'h01, 4'h0});
    chk(stb, 1'b1);
    t_unmapped();
    t_modes();
    t_ramp();
    test_done();
  end
endmodule
`default_nettype wire
